//--- rtl/flash_seq_pkg.sv
// Constants and types for the flash program and erase sequencer
package flash_seq_pkg;
    // Timing-generator clock band, kHz
    localparam int TIMING_CLK_MIN_KHZ = 257;
    localparam int TIMING_CLK_MAX_KHZ = 476;
    // System clock, MHz
    localparam int SYS_CLK_MHZ = 50;
    // Phase durations in timing-generator periods
    localparam logic [13:0] WORD_PROG_TICKS = 14'd30;
    localparam logic [13:0] BLOCK_FIRST_TICKS = 14'd25;
    localparam logic [13:0] BLOCK_NEXT_TICKS = 14'd18;
    localparam logic [13:0] BLOCK_END_TICKS = 14'd6;
    localparam logic [13:0] MASS_ERASE_TICKS = 14'd10593;
    localparam logic [13:0] SEG_ERASE_TICKS = 14'd4819;
    // Block and segment geometry
    localparam int BLOCK_BYTES = 64;
    localparam int MAIN_SEG_BYTES = 512;
    localparam int INFO_SEG_BYTES = 64;
    localparam int INFO_SEG_COUNT = 4;
    localparam logic [15:0] INFO_BASE = 16'h1000;
    localparam logic [15:0] INFO_END = 16'h10ff;
    localparam logic [15:0] CAL_SEG_BASE = 16'h1000;
    localparam logic [15:0] CAL_SEG_END = 16'h103f;
    // Operation codes on the request port
    localparam logic [2:0] OP_WORD = 3'h0;
    localparam logic [2:0] OP_BYTE = 3'h1;
    localparam logic [2:0] OP_BLOCK = 3'h2;
    localparam logic [2:0] OP_SEG_ERASE = 3'h3;
    localparam logic [2:0] OP_MASS_ERASE = 3'h4;
    localparam logic [2:0] OP_MAIN_ERASE = 3'h5;
    localparam logic RESET_CAL_LOCKED = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE, ST_WORD, ST_BLK_FIRST, ST_BLK_WAIT, ST_BLK_NEXT, ST_BLK_END, ST_ERASE
    } seq_state_t;
endpackage

//--- rtl/flash_program_erase_timing.sv
// Flash program and erase timing sequencer
`timescale 1ns/1ps
// Contract
// - Word or byte program lasts 30 periods
// - First block word programs for 25 periods
// - Each further block word takes 18 periods
// - Block end waits 6 periods before done
// - Mass erase 10593, segment erase 4819 periods
// - 512-byte main, four 64-byte info segments
// - Calibration segment locked after reset
// - Accept single byte and word writes
module flash_program_erase_timing
    import flash_seq_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flash_timing_clock,
    input wire logic req_valid,
    input wire logic [2:0] req_op,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_data,
    input wire logic blk_data_valid,
    input wire logic [15:0] blk_data,
    input wire logic blk_last,
    input wire logic cal_unlock,
    input wire logic cal_lock,
    output logic busy,
    output logic done,
    output logic denied,
    output logic blk_ready,
    output logic arr_prog,
    output logic arr_erase,
    output logic arr_mass,
    output logic arr_byte,
    output logic [15:0] arr_addr,
    output logic [15:0] arr_data,
    output logic cal_locked
);
    typedef struct packed {
        seq_state_t state;
        logic [13:0] ticks;
        logic tclk_prev;
        logic busy;
        logic done;
        logic denied;
        logic blk_ready;
        logic prog;
        logic erase;
        logic mass;
        logic byte_mode;
        logic [15:0] addr;
        logic [15:0] data;
        logic [5:0] blk_idx;
        logic cal_locked;
    } seq_regs_t;

    seq_regs_t state_r;
    seq_regs_t state_nxt;
    logic tick;
    logic in_cal;
    logic new_op;

    // Timing clock is treated as a synchronous level; rising edges count periods
    assign tick = flash_timing_clock & ~state_r.tclk_prev;
    assign in_cal = (req_addr >= CAL_SEG_BASE) && (req_addr <= CAL_SEG_END);
    assign new_op = req_valid && (state_r.state == ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        state_nxt.tclk_prev = flash_timing_clock;
        state_nxt.done = 1'b0;
        state_nxt.denied = 1'b0;
        if (cal_unlock) begin
            state_nxt.cal_locked = 1'b0;
        end
        if (cal_lock) begin
            state_nxt.cal_locked = 1'b1;
        end
        unique case (state_r.state)
            ST_IDLE: begin
                if (new_op) begin
                    state_nxt.addr = req_addr;
                    state_nxt.data = req_data;
                    state_nxt.blk_idx = 6'h00;
                    state_nxt.byte_mode = (req_op == OP_BYTE);
                    state_nxt.mass = 1'b0;
                    // Locked calibration segment refuses program and segment erase
                    if (in_cal && state_r.cal_locked && req_op != OP_MASS_ERASE
                        && req_op != OP_MAIN_ERASE) begin
                        state_nxt.denied = 1'b1;
                    end else if (req_op == OP_WORD || req_op == OP_BYTE) begin
                        state_nxt.state = ST_WORD;
                        state_nxt.ticks = WORD_PROG_TICKS;
                        state_nxt.prog = 1'b1;
                        state_nxt.busy = 1'b1;
                    end else if (req_op == OP_BLOCK) begin
                        state_nxt.state = ST_BLK_FIRST;
                        state_nxt.ticks = BLOCK_FIRST_TICKS;
                        state_nxt.prog = 1'b1;
                        state_nxt.busy = 1'b1;
                    end else if (req_op == OP_SEG_ERASE) begin
                        state_nxt.state = ST_ERASE;
                        state_nxt.ticks = SEG_ERASE_TICKS;
                        state_nxt.erase = 1'b1;
                        state_nxt.busy = 1'b1;
                    end else if (req_op == OP_MASS_ERASE || req_op == OP_MAIN_ERASE) begin
                        // Mass and main erase run the same way and set arr_mass whatever the calibration lock
                        state_nxt.state = ST_ERASE;
                        state_nxt.ticks = MASS_ERASE_TICKS;
                        state_nxt.erase = 1'b1;
                        state_nxt.mass = 1'b1;
                        state_nxt.busy = 1'b1;
                    end else begin
                        state_nxt.denied = 1'b1;
                    end
                end
            end
            ST_WORD, ST_ERASE, ST_BLK_FIRST, ST_BLK_NEXT: begin
                if (tick) begin
                    state_nxt.ticks = state_r.ticks - 14'd1;
                end
                if (tick && state_r.ticks == 14'd1) begin
                    state_nxt.prog = 1'b0;
                    state_nxt.erase = 1'b0;
                    if (state_r.state == ST_WORD || state_r.state == ST_ERASE) begin
                        state_nxt.state = ST_IDLE;
                        state_nxt.busy = 1'b0;
                        state_nxt.done = 1'b1;
                    end else if (blk_last || state_r.blk_idx == 6'h3f) begin
                        state_nxt.state = ST_BLK_END;
                        state_nxt.ticks = BLOCK_END_TICKS;
                    end else begin
                        state_nxt.state = ST_BLK_WAIT;
                        state_nxt.blk_ready = 1'b1;
                    end
                end
            end
            ST_BLK_WAIT: begin
                // Busy stays high between block words; the block is one phase
                if (blk_data_valid) begin
                    state_nxt.blk_ready = 1'b0;
                    state_nxt.data = blk_data;
                    state_nxt.addr = state_r.addr + 16'h0002;
                    state_nxt.blk_idx = state_r.blk_idx + 6'h01;
                    state_nxt.state = ST_BLK_NEXT;
                    state_nxt.ticks = BLOCK_NEXT_TICKS;
                    state_nxt.prog = 1'b1;
                end
            end
            ST_BLK_END: begin
                if (tick) begin
                    state_nxt.ticks = state_r.ticks - 14'd1;
                end
                if (tick && state_r.ticks == 14'd1) begin
                    state_nxt.state = ST_IDLE;
                    state_nxt.busy = 1'b0;
                    state_nxt.done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= '0;
            state_r.state <= ST_IDLE;
            state_r.cal_locked <= RESET_CAL_LOCKED;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign busy = state_r.busy;
    assign done = state_r.done;
    assign denied = state_r.denied;
    assign blk_ready = state_r.blk_ready;
    assign arr_prog = state_r.prog;
    assign arr_erase = state_r.erase;
    assign arr_mass = state_r.mass;
    assign arr_byte = state_r.byte_mode;
    assign arr_addr = state_r.addr;
    assign arr_data = state_r.data;
    assign cal_locked = state_r.cal_locked;

    // Count timing edges across each program or erase pulse for the checks below
    logic [13:0] pulse_ticks;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pulse_ticks <= 14'd0;
        end else if (!(arr_prog || arr_erase)) begin
            pulse_ticks <= 14'd0;
        end else if (tick) begin
            pulse_ticks <= pulse_ticks + 14'd1;
        end
    end

    AST_WORD_LEN: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(arr_prog) && $past(state_r.state) == ST_WORD |-> $past(pulse_ticks) == 14'd29)
        else $error("word program length wrong");
    AST_BLK_FIRST: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(arr_prog) && $past(state_r.state) == ST_BLK_FIRST |-> $past(pulse_ticks) == 14'd24)
        else $error("first block word length wrong");
    AST_BLK_NEXT: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(arr_prog) && $past(state_r.state) == ST_BLK_NEXT |-> $past(pulse_ticks) == 14'd17)
        else $error("block word length wrong");
    AST_BLK_END: assert property (@(posedge sys_clk) disable iff (rst)
        state_r.state == ST_BLK_END && !$past(state_r.state == ST_BLK_END)
        |-> state_r.ticks == 14'd6)
        else $error("block end wait wrong");
    AST_ERASE_LEN: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(arr_erase) |-> $past(pulse_ticks) == (arr_mass ? 14'd10592 : 14'd4818))
        else $error("erase length wrong");
    AST_CAL_LOCK: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(arr_prog) && state_r.state == ST_WORD && cal_locked
        |-> !(arr_addr >= CAL_SEG_BASE && arr_addr <= CAL_SEG_END))
        else $error("locked calibration programmed");
    AST_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
        (arr_prog || arr_erase) |-> busy)
        else $error("phase without busy");
    AST_DONE: assert property (@(posedge sys_clk) disable iff (rst)
        done |-> !busy && $past(busy))
        else $error("done without phase end");
    AST_SINGLE: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(busy) && state_r.state == ST_WORD |-> arr_prog ##1 arr_prog)
        else $error("single write not started");

    COV_WORD: cover property (@(posedge sys_clk) disable iff (rst)
        $fell(arr_prog) && $past(state_r.state) == ST_WORD);
    COV_BLOCK: cover property (@(posedge sys_clk) disable iff (rst)
        done && $past(state_r.state) == ST_BLK_END);
    COV_SEG: cover property (@(posedge sys_clk) disable iff (rst) $fell(arr_erase) && !arr_mass);
    COV_DENY: cover property (@(posedge sys_clk) disable iff (rst) denied);
endmodule // flash_program_erase_timing

//--- sim/flash_array_model.sv
// Far-side model: timing-generator clock, per-pulse tick counter and busy-gap tick counter
`timescale 1ns/1ps
module flash_array_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic busy,
    input wire logic arr_prog,
    input wire logic arr_erase,
    output logic flash_timing_clock,
    output logic [13:0] pulse_ticks,
    output logic [13:0] gap_ticks
);
    // Runs far above the real band to keep erase runs short; counts unaffected
    logic div;
    logic tq;
    logic act_q;
    wire act = arr_prog | arr_erase;
    wire tick = flash_timing_clock & ~tq;
    initial begin
        flash_timing_clock = 1'b0;
        div = 1'b0;
    end
    always @(negedge sys_clk) begin
        div <= ~div;
        if (!slow || div) flash_timing_clock <= ~flash_timing_clock;
    end
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tq <= 1'b0;
            act_q <= 1'b0;
            pulse_ticks <= 14'h0;
            gap_ticks <= 14'h0;
        end else begin
            tq <= flash_timing_clock;
            act_q <= act;
            if (act && !act_q) pulse_ticks <= {13'h0, tick};
            else if (act && tick) pulse_ticks <= pulse_ticks + 14'h1;
            if (act) gap_ticks <= 14'h0;
            else if (busy && tick) gap_ticks <= gap_ticks + 14'h1;
        end
    end
endmodule // flash_array_model

//--- sim/flash_program_erase_timing_tb_top.sv
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ps
module flash_program_erase_timing_tb_top;
    import flash_seq_pkg::*;
    logic sys_clk, rst, flash_timing_clock, req_valid, blk_data_valid, blk_last;
    logic cal_unlock, cal_lock, slow, busy, done, denied, blk_ready;
    logic arr_prog, arr_erase, arr_mass, arr_byte, cal_locked;
    logic [2:0] req_op;
    logic [15:0] req_addr, req_data, blk_data, arr_addr, arr_data, a, d;
    logic [13:0] pulse_ticks, gap_ticks;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    int prog_sum;
    flash_program_erase_timing dut (.sys_clk, .rst, .flash_timing_clock, .req_valid,
        .req_op, .req_addr, .req_data, .blk_data_valid, .blk_data, .blk_last, .cal_unlock,
        .cal_lock, .busy, .done, .denied, .blk_ready, .arr_prog, .arr_erase, .arr_mass,
        .arr_byte, .arr_addr, .arr_data, .cal_locked);
    flash_array_model model (.sys_clk, .rst, .slow, .busy, .arr_prog, .arr_erase,
        .flash_timing_clock, .pulse_ticks, .gap_ticks);
    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Request held over one rising edge; returns at the following falling edge
    task automatic issue(logic [2:0] op, logic [15:0] ad, logic [15:0] dt);
        req_op = op;
        req_addr = ad;
        req_data = dt;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 30000 && done !== 1'b1; i++) @(negedge sys_clk);
        chk("done", 16'h1, {15'h0, done});
        @(negedge sys_clk);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        // Ceiling well above the roughly 60k cycles the tests need
        if (cyc == 80000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        {rst, req_valid, blk_data_valid, blk_last, cal_unlock, cal_lock, slow} = 7'h40;
        {req_op, req_addr, req_data, blk_data} = '0;
        void'($urandom(32'h64434ac7));
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        chk("cal_locked", 16'h1, 16'(cal_locked));
        for (int k = 0; k < 4; k++) begin
            slow = k[1];
            a = 16'hc000 | (16'($urandom) & 16'h3ffe);
            d = 16'($urandom);
            issue(k[0] ? OP_BYTE : OP_WORD, a, d);
            chk("busy", 16'h1, 16'(busy));
            chk("arr_prog", 16'h1, 16'(arr_prog));
            chk("arr_byte", 16'(k[0]), 16'(arr_byte));
            chk("arr_addr", a, arr_addr);
            chk("arr_data", d & 16'h00ff, arr_data & 16'h00ff);
            // Let an edge pass so the strobe is not raised again in one step
            @(negedge sys_clk);
            issue(OP_MASS_ERASE, a, d);
            wait_done();
            chk("word ticks", 16'd30, 16'(pulse_ticks));
            chk("idle", 16'h0, 16'(busy));
            chk("no erase", 16'h0, 16'(arr_mass));
        end
        for (int b = 0; b < 2; b++) begin
            n = b ? 64 : 2 + ($urandom % 6);
            slow = b[0];
            blk_last = 1'b0;
            prog_sum = 0;
            issue(OP_BLOCK, 16'he000 + 16'(b * 128), 16'($urandom));
            for (int i = 1; i < n; i++) begin
                for (int w = 0; w < 2000 && blk_ready !== 1'b1; w++) @(negedge sys_clk);
                chk("blk_ready", 16'h1, 16'(blk_ready));
                chk("blk ticks", i == 1 ? 16'd25 : 16'd18, 16'(pulse_ticks));
                prog_sum += int'(pulse_ticks);
                blk_data = 16'($urandom);
                blk_last = (i == n - 1);
                blk_data_valid = 1'b1;
                @(negedge sys_clk);
                blk_data_valid = 1'b0;
                chk("blk addr", 16'he000 + 16'(b * 128) + 16'(2 * i), arr_addr);
                chk("blk data", blk_data, arr_data);
            end
            wait_done();
            prog_sum += int'(pulse_ticks);
            chk("last ticks", 16'd18, 16'(pulse_ticks));
            chk("end wait", 16'd6, 16'(gap_ticks));
            // Stimulus keeps a block's programming under the ceiling at the slowest clock
            chk("cum prog", 16'h1, 16'(prog_sum <= 10 * TIMING_CLK_MIN_KHZ));
        end
        // Fast timing clock keeps the long erases inside the run budget
        slow = 1'b0;
        // Mass and main erase aimed at the locked segment must still run
        for (int k = 0; k < 3; k++) begin
            issue(OP_SEG_ERASE + 3'(k), k ? CAL_SEG_BASE : 16'hc200, 16'h0);
            chk("arr_erase", 16'h1, 16'(arr_erase));
            chk("arr_mass", 16'(k != 0), 16'(arr_mass));
            wait_done();
            chk("erase ticks", k ? 16'd10593 : 16'd4819, 16'(pulse_ticks));
            // One mass erase must reach the minimum even at the fastest clock
            if (k != 0) chk("cum erase", 16'h1, 16'(int'(pulse_ticks) >= 20 * TIMING_CLK_MAX_KHZ));
        end
        issue(OP_WORD, CAL_SEG_BASE, 16'h1234);
        chk("denied", 16'h1, 16'(denied));
        chk("busy", 16'h0, 16'(busy));
        @(negedge sys_clk);
        issue(OP_SEG_ERASE, CAL_SEG_END, 16'h0);
        chk("denied", 16'h1, 16'(denied));
        @(negedge sys_clk);
        issue(3'h7, 16'hc000, 16'h0);
        chk("denied", 16'h1, 16'(denied));
        chk("busy", 16'h0, 16'(busy));
        @(negedge sys_clk);
        issue(OP_WORD, INFO_END - 16'h1, 16'h5a5a);
        chk("denied", 16'h0, 16'(denied));
        wait_done();
        cal_unlock = 1'b1;
        @(negedge sys_clk);
        cal_unlock = 1'b0;
        @(negedge sys_clk);
        chk("cal_locked", 16'h0, 16'(cal_locked));
        issue(OP_WORD, CAL_SEG_BASE + 16'h2, 16'h0f0f);
        chk("denied", 16'h0, 16'(denied));
        wait_done();
        cal_lock = 1'b1;
        @(negedge sys_clk);
        cal_lock = 1'b0;
        @(negedge sys_clk);
        chk("cal_locked", 16'h1, 16'(cal_locked));
        report_and_stop();
    end
endmodule // flash_program_erase_timing_tb_top
